// [logic/adc_ctl_pkg.sv]
// shared constants, register map and carrier types for the converter control block
package adc_ctl_pkg;

  localparam int          ADDR_W       = 8;
  localparam int          RES_W        = 10;
  localparam int          TRIG_N       = 17;

  // register byte offsets
  localparam logic [7:0]  OFF_CTRL0    = 8'h00;
  localparam logic [7:0]  OFF_TRIG     = 8'h04;
  localparam logic [7:0]  OFF_RES_HI   = 8'h08;
  localparam logic [7:0]  OFF_RES_LO   = 8'h0c;
  localparam logic [7:0]  OFF_INT_STAT = 8'h10;
  localparam logic [7:0]  OFF_INT_MASK = 8'h14;
  localparam logic [7:0]  OFF_STATE    = 8'h18;

  // converter_control_0 field positions
  localparam int          CTL_ON_BIT   = 0;
  localparam int          CTL_GO_BIT   = 1;
  localparam int          CTL_RC_BIT   = 2;

  // interrupt status / mask field positions
  localparam int          INT_DONE_BIT = 0;
  localparam int          INT_SLP_BIT  = 1;
  localparam int          INT_W        = 2;

  // reset values
  localparam logic [4:0]  TRIG_RST     = 5'h00;
  localparam logic [9:0]  RES_RST      = 10'h000;
  localparam logic [1:0]  INT_RST      = 2'h0;

  // axi response codes
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // timing
  localparam int          CLK_NS       = 100;
  localparam int          INSTR_NS     = 400;
  localparam int          SAMPLE_NS    = 1000;
  localparam int          SETTLE_NS    = 400;
  localparam logic [7:0]  RC_DELAY_CYC = 8'((INSTR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  SAMPLE_CYC   = 8'((SAMPLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  SETTLE_CYC   = 8'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0]  MSB_IDX      = 4'(RES_W - 1);

  // drive towards the analog sample-and-hold and comparator dac
  typedef struct packed {
    logic             sample_en;
    logic [RES_W-1:0] code;
  } sar_drive_t;

  typedef struct packed {
    logic on;
    logic go;
    logic rc_sel;
  } ctrl_t;

endpackage

// [logic/sync_edge.sv]
// two-stage synchroniser with rising edge detection per bit
`timescale 1ns/1ps
`default_nettype none
module sync_edge #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;
  logic [W-1:0] prev_r;
  logic [W-1:0] rise_r;

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      rise_r <= '0;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
      rise_r <= sync_r & ~prev_r;
    end
  end

  assign level = prev_r;
  assign rise  = rise_r;

endmodule
`default_nettype wire

// [logic/sar_engine.sv]
// successive approximation sequencer: sample phase, bit trials, abort fill
`timescale 1ns/1ps
`default_nettype none
module sar_engine (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     start,
  input  wire logic                     abort,
  input  wire logic                     cmp_high,
  output logic                          busy,
  output adc_ctl_pkg::sar_drive_t       drive,
  output logic                          res_valid,
  output logic [adc_ctl_pkg::RES_W-1:0] result,
  output logic                          done,
  output logic [3:0]                    bit_idx
);
  import adc_ctl_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_TRIAL} sar_state_t;

  sar_state_t       state_r, state_nxt;
  logic [7:0]       cnt_r, cnt_nxt;
  logic [3:0]       idx_r, idx_nxt;
  logic [RES_W-1:0] code_r, code_nxt;
  logic             smp_r, smp_nxt;
  logic             rv_r, rv_nxt;
  logic             done_r, done_nxt;
  logic [RES_W-1:0] res_r, res_nxt;
  logic [RES_W-1:0] fill;
  logic [RES_W-1:0] kept;
  logic             last_bit;

  always_comb begin
    // unresolved bits copy the last resolved one
    last_bit = (idx_r == MSB_IDX) ? 1'b0 : code_r[idx_r + 4'd1]; // RULE7
    for (int i = 0; i < RES_W; i++) begin
      fill[i] = (4'(i) <= idx_r) ? last_bit : code_r[i]; // RULE7
    end
    kept         = code_r;
    kept[idx_r]  = cmp_high;
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    idx_nxt      = idx_r;
    code_nxt     = code_r;
    smp_nxt      = smp_r;
    rv_nxt       = 1'b0;
    done_nxt     = 1'b0;
    res_nxt      = res_r;
    case (state_r)
      S_IDLE: begin
        if (start) begin
          state_nxt = S_SAMPLE;
          cnt_nxt   = SAMPLE_CYC - 8'd1;
          code_nxt  = '0;
          smp_nxt   = 1'b1;
        end
      end
      S_SAMPLE: begin
        if (abort) begin
          state_nxt = S_IDLE;
          smp_nxt   = 1'b0;
          res_nxt   = '0; // RULE6
          rv_nxt    = 1'b1;
        end else if (cnt_r == 8'd0) begin
          state_nxt = S_TRIAL;
          smp_nxt   = 1'b0;
          idx_nxt   = MSB_IDX;
          code_nxt  = RES_W'(1) << MSB_IDX;
          cnt_nxt   = SETTLE_CYC - 8'd1;
        end else begin
          cnt_nxt = cnt_r - 8'd1;
        end
      end
      S_TRIAL: begin
        if (abort) begin
          state_nxt = S_IDLE;
          res_nxt   = fill; // RULE6
          rv_nxt    = 1'b1;
        end else if (cnt_r == 8'd0) begin
          // keep the trial bit when the input sits above the dac level
          if (idx_r == 4'd0) begin
            state_nxt = S_IDLE;
            code_nxt  = kept;
            res_nxt   = kept; // RULE5
            rv_nxt    = 1'b1;
            done_nxt  = 1'b1;
          end else begin
            idx_nxt  = idx_r - 4'd1;
            code_nxt = kept | (RES_W'(1) << (idx_r - 4'd1)); // RULE5
            cnt_nxt  = SETTLE_CYC - 8'd1;
          end
        end else begin
          cnt_nxt = cnt_r - 8'd1;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= S_IDLE;
      cnt_r   <= 8'd0;
      idx_r   <= 4'd0;
      code_r  <= '0;
      smp_r   <= 1'b0;
      rv_r    <= 1'b0;
      done_r  <= 1'b0;
      res_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      idx_r   <= idx_nxt;
      code_r  <= code_nxt;
      smp_r   <= smp_nxt;
      rv_r    <= rv_nxt;
      done_r  <= done_nxt;
      res_r   <= res_nxt;
    end
  end

  assign busy            = (state_r != S_IDLE);
  assign drive.sample_en = smp_r;
  assign drive.code      = code_r;
  assign res_valid       = rv_r;
  assign result          = res_r;
  assign done            = done_r;
  assign bit_idx         = idx_r;

endmodule
`default_nettype wire

// [logic/adc_conversion_control.sv]
// converter sequencing top: axi4-lite registers, start/stop, sleep handling, triggers
//
// Contract
// RULE1 - software sets converter_on to enable the block; cleared means disabled
// RULE2 - writing one to convert_go starts a conversion; reads one while running
// RULE3 - software should not set convert_go in the write that turns converter_on
// RULE4 - on completion clear convert_go, set done flag, load result pair
// RULE5 - each conversion yields ten bits by successive approximation into the result pair
// RULE6 - clearing convert_go early stops conversion and stores the partial value
// RULE7 - after early stop, unresolved bits copy the last converted bit
// RULE8 - any reset restores all registers, converter off, conversion terminated
// RULE9 - conversion continues during sleep only with the dedicated rc clock selected
// RULE10 - with dedicated rc clock, start is delayed one extra instruction cycle
// RULE11 - completion during sleep with interrupt enabled raises a wake-up event
// RULE12 - completion during sleep with interrupt disabled powers converter down, on bit kept
// RULE13 - sleep without rc clock aborts conversion and powers down, on bit kept
// RULE14 - rising edge on selected trigger source sets convert_go in hardware
// RULE15 - trigger source chosen by five-bit trigger_select field, bits four to zero
// RULE16 - sources: timer overflows, period matches, comparators, logic cells, capture units
// RULE17 - trigger edges ignored while converter off or a conversion is running
// RULE18 - done flag stays set until software clears it; drives interrupt when enabled
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control (
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  input  wire logic [adc_ctl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                           s_axi_awvalid,
  output logic                                s_axi_awready,
  input  wire logic [31:0]                    s_axi_wdata,
  input  wire logic [3:0]                     s_axi_wstrb,
  input  wire logic                           s_axi_wvalid,
  output logic                                s_axi_wready,
  output logic [1:0]                          s_axi_bresp,
  output logic                                s_axi_bvalid,
  input  wire logic                           s_axi_bready,
  input  wire logic [adc_ctl_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                           s_axi_arvalid,
  output logic                                s_axi_arready,
  output logic [31:0]                         s_axi_rdata,
  output logic [1:0]                          s_axi_rresp,
  output logic                                s_axi_rvalid,
  input  wire logic                           s_axi_rready,
  input  wire logic [adc_ctl_pkg::TRIG_N-1:0] trig_src,
  input  wire logic                           cmp_in,
  input  wire logic                           sleep_in,
  output adc_ctl_pkg::sar_drive_t             analog_drive,
  output logic                                converter_powered,
  output logic                                wake_req,
  output logic                                irq
);
  import adc_ctl_pkg::*;

  // axi slave state
  logic        awready_r, awready_nxt;
  logic        wready_r, wready_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        arready_r, arready_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        aw_have_r, aw_have_nxt;
  logic        w_have_r, w_have_nxt;
  logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        wr_en;
  logic        wr_low;
  logic        wr_hit;

  // block state
  ctrl_t       ctl_r, ctl_nxt;
  logic [4:0]  trig_sel_r, trig_sel_nxt;
  logic [RES_W-1:0] res_r, res_nxt;
  logic [INT_W-1:0] stat_r, stat_nxt;
  logic [INT_W-1:0] mask_r, mask_nxt;
  logic [7:0]  dly_r, dly_nxt;
  logic        dly_act_r, dly_act_nxt;
  logic        pdn_r, pdn_nxt;
  logic        wake_r, wake_nxt;
  logic        irq_r, irq_nxt;
  logic        pwr_r, pwr_nxt;

  // helpers
  logic [TRIG_N-1:0] trig_rise;
  logic        cmp_level;
  logic        trig_hit;
  logic        sw_go_set;
  logic        sw_go_clr;
  logic        sw_off;
  logic        sleep_abort;
  logic        start_req;
  logic        eng_start;
  logic        eng_abort;
  logic        eng_busy;
  logic        eng_rv;
  logic        eng_done;
  logic [RES_W-1:0] eng_res;
  logic [3:0]  eng_idx;
  logic [INT_W-1:0] stat_set;
  logic [INT_W-1:0] stat_clr;

  sync_edge #(.W(TRIG_N)) u_trig_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (trig_src),
    .level    (),
    .rise     (trig_rise)
  );

  sync_edge #(.W(1)) u_cmp_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (cmp_in),
    .level    (cmp_level),
    .rise     ()
  );

  sar_engine u_sar (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .start     (eng_start),
    .abort     (eng_abort),
    .cmp_high  (cmp_level),
    .busy      (eng_busy),
    .drive     (analog_drive),
    .res_valid (eng_rv),
    .result    (eng_res),
    .done      (eng_done),
    .bit_idx   (eng_idx)
  );

  // axi4-lite write and read channels
  always_comb begin
    aw_have_nxt = aw_have_r | (s_axi_awvalid & awready_r);
    w_have_nxt  = w_have_r | (s_axi_wvalid & wready_r);
    awaddr_nxt  = (s_axi_awvalid & awready_r) ? s_axi_awaddr : awaddr_r;
    wdata_nxt   = (s_axi_wvalid & wready_r) ? s_axi_wdata : wdata_r;
    wstrb_nxt   = (s_axi_wvalid & wready_r) ? s_axi_wstrb : wstrb_r;
    bvalid_nxt  = bvalid_r & ~s_axi_bready;
    bresp_nxt   = bresp_r;
    wr_en       = aw_have_r & w_have_r & ~bvalid_r;
    wr_low      = wr_en & wstrb_r[0];
    wr_hit      = (awaddr_r == OFF_CTRL0) || (awaddr_r == OFF_TRIG) || (awaddr_r == OFF_INT_STAT) ||
                  (awaddr_r == OFF_INT_MASK) || (awaddr_r == OFF_RES_HI) || (awaddr_r == OFF_RES_LO) ||
                  (awaddr_r == OFF_STATE);
    if (wr_en) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    awready_nxt = ~aw_have_nxt & ~bvalid_nxt & ~wr_en;
    wready_nxt  = ~w_have_nxt & ~bvalid_nxt & ~wr_en;
    rvalid_nxt  = rvalid_r & ~s_axi_rready;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (s_axi_arvalid & arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      case (s_axi_araddr)
        OFF_CTRL0:    rdata_nxt = {29'h0, ctl_r.rc_sel, ctl_r.go, ctl_r.on}; // RULE2
        OFF_TRIG:     rdata_nxt = {27'h0, trig_sel_r};
        OFF_RES_HI:   rdata_nxt = {30'h0, res_r[9:8]};
        OFF_RES_LO:   rdata_nxt = {24'h0, res_r[7:0]};
        OFF_INT_STAT: rdata_nxt = {30'h0, stat_r};
        OFF_INT_MASK: rdata_nxt = {30'h0, mask_r};
        OFF_STATE:    rdata_nxt = {24'h0, eng_busy, dly_act_r, pdn_r, pwr_r, eng_idx};
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    arready_nxt = ~rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OKAY;
      rdata_r   <= 32'h0;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= 32'h0;
      wstrb_r   <= 4'h0;
    end else begin
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
    end
  end

  // conversion control
  always_comb begin
    trig_hit = 1'b0;
    if ((trig_sel_r != 5'h00) && (trig_sel_r <= 5'(TRIG_N))) begin
      trig_hit = trig_rise[trig_sel_r - 5'd1]; // RULE15 RULE16
    end
    // go set in the write that also turns the block on is not honoured
    sw_go_set   = wr_low && (awaddr_r == OFF_CTRL0) && wdata_r[CTL_GO_BIT] && ctl_r.on; // RULE3
    sw_go_clr   = wr_low && (awaddr_r == OFF_CTRL0) && !wdata_r[CTL_GO_BIT];
    sw_off      = wr_low && (awaddr_r == OFF_CTRL0) && !wdata_r[CTL_ON_BIT];
    sleep_abort = sleep_in && !ctl_r.rc_sel; // RULE9 RULE13
    start_req   = !ctl_r.go && ctl_r.on && !sleep_abort && (sw_go_set || trig_hit); // RULE1 RULE14 RULE17
    ctl_nxt     = ctl_r;
    dly_nxt     = dly_r;
    dly_act_nxt = dly_act_r;
    eng_start   = 1'b0;
    eng_abort   = 1'b0;
    if (wr_low && (awaddr_r == OFF_CTRL0)) begin
      ctl_nxt.on     = wdata_r[CTL_ON_BIT]; // RULE1
      ctl_nxt.rc_sel = wdata_r[CTL_RC_BIT];
    end
    if (ctl_r.go && (sw_go_clr || sw_off || sleep_abort)) begin
      ctl_nxt.go  = 1'b0; // RULE6 RULE13
      eng_abort   = eng_busy;
      dly_act_nxt = 1'b0;
    end else if (ctl_r.go && eng_done) begin
      ctl_nxt.go = 1'b0; // RULE4
    end else if (start_req) begin
      ctl_nxt.go = 1'b1; // RULE2 RULE14
      if (ctl_r.rc_sel) begin
        dly_act_nxt = 1'b1; // RULE10
        dly_nxt     = RC_DELAY_CYC - 8'd1;
      end else begin
        eng_start = 1'b1;
      end
    end else if (dly_act_r) begin
      if (dly_r == 8'd0) begin
        dly_act_nxt = 1'b0;
        eng_start   = 1'b1; // RULE10
      end else begin
        dly_nxt = dly_r - 8'd1;
      end
    end
    trig_sel_nxt = (wr_low && (awaddr_r == OFF_TRIG)) ? wdata_r[4:0] : trig_sel_r; // RULE15
    mask_nxt     = (wr_low && (awaddr_r == OFF_INT_MASK)) ? wdata_r[INT_W-1:0] : mask_r;
    res_nxt      = eng_rv ? eng_res : res_r; // RULE4 RULE6
    stat_set     = '0;
    stat_set[INT_DONE_BIT] = eng_done; // RULE4
    stat_set[INT_SLP_BIT]  = ctl_r.go && sleep_abort;
    stat_clr     = (wr_low && (awaddr_r == OFF_INT_STAT)) ? wdata_r[INT_W-1:0] : '0;
    // a new event beats a simultaneous write-one-to-clear
    stat_nxt     = (stat_r & ~stat_clr) | stat_set; // RULE18
    irq_nxt      = |(stat_nxt & mask_nxt); // RULE18
    wake_nxt     = eng_done && sleep_in && mask_r[INT_DONE_BIT]; // RULE11
    // power-down lasts until sleep ends; converter_on itself is untouched
    pdn_nxt      = sleep_in && (pdn_r || !ctl_r.rc_sel || (eng_done && !mask_r[INT_DONE_BIT])); // RULE12 RULE13
    pwr_nxt      = ctl_nxt.on && !pdn_nxt; // RULE1
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_r      <= '0; // RULE8
      trig_sel_r <= TRIG_RST;
      res_r      <= RES_RST;
      stat_r     <= INT_RST;
      mask_r     <= INT_RST;
      dly_r      <= 8'd0;
      dly_act_r  <= 1'b0;
      pdn_r      <= 1'b0;
      wake_r     <= 1'b0;
      irq_r      <= 1'b0;
      pwr_r      <= 1'b0;
    end else begin
      ctl_r      <= ctl_nxt;
      trig_sel_r <= trig_sel_nxt;
      res_r      <= res_nxt;
      stat_r     <= stat_nxt;
      mask_r     <= mask_nxt;
      dly_r      <= dly_nxt;
      dly_act_r  <= dly_act_nxt;
      pdn_r      <= pdn_nxt;
      wake_r     <= wake_nxt;
      irq_r      <= irq_nxt;
      pwr_r      <= pwr_nxt;
    end
  end

  assign s_axi_awready     = awready_r;
  assign s_axi_wready      = wready_r;
  assign s_axi_bvalid      = bvalid_r;
  assign s_axi_bresp       = bresp_r;
  assign s_axi_arready     = arready_r;
  assign s_axi_rvalid      = rvalid_r;
  assign s_axi_rresp       = rresp_r;
  assign s_axi_rdata       = rdata_r;
  assign converter_powered = pwr_r;
  assign wake_req          = wake_r;
  assign irq               = irq_r;

endmodule
`default_nettype wire

// [dv/adc_ctl_sva.sv]
// port assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_ctl_sva (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic [31:0]             s_axi_rdata,
  input wire adc_ctl_pkg::sar_drive_t analog_drive,
  input wire logic                    converter_powered,
  input wire logic                    wake_req,
  input wire logic                    irq,
  input wire logic                    sleep_in
);
  import adc_ctl_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !irq && !wake_req && !converter_powered)
    else $error("outputs active after reset");
  a_sample_len: assert property ($rose(analog_drive.sample_en) ##1 analog_drive.sample_en[*8] ##1
    analog_drive.sample_en |=> !analog_drive.sample_en)
    else $error("sample phase longer than ten cycles");
  a_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake request longer than one cycle");
  a_wake_sleep: assert property (wake_req |-> $past(sleep_in))
    else $error("wake request outside sleep");
  a_wake_irq: assert property (wake_req |-> ##[0:2] irq)
    else $error("wake without interrupt");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed");
  a_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken during response");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during response");
endmodule
`default_nettype wire

// [dv/adc_core_model.sv]
// behavioural sample-and-hold and comparator
`timescale 1ns/1ps
`default_nettype none
module adc_core_model #(
  parameter int SLOW = 0
) (
  input  wire logic                    aclk,
  input  wire adc_ctl_pkg::sar_drive_t drive,
  input  wire logic [9:0]              vin,
  output logic                         cmp_out
);
  import adc_ctl_pkg::*;
  logic tgl = 1'b0;
  logic cmp_r = 1'b0;
  // output means nothing while sampling, so it toggles
  always @(posedge aclk) tgl <= ~tgl;
  always @(posedge aclk) cmp_r <= (vin >= drive.code);
  assign cmp_out = drive.sample_en ? tgl : (SLOW != 0 ? cmp_r : (vin >= drive.code));
endmodule
`default_nettype wire

// [dv/tb_adc_conversion_control.sv]
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_control;
  import adc_ctl_pkg::*;
  logic              aclk;
  logic              aresetn = 1'b0;
  logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'hf;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sleep_in = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rresp;
  logic [TRIG_N-1:0] trig_src = '0;
  logic [9:0]        vin = 10'h000;
  logic              cmp_in, converter_powered, wake_req, irq;
  sar_drive_t        analog_drive;
  int                err_count = 0;
  int                tests_run = 0;

  adc_conversion_control dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trig_src,
    .cmp_in, .sleep_in, .analog_drive, .converter_powered, .wake_req, .irq);
  adc_core_model core (.aclk, .drive(analog_drive), .vin, .cmp_out(cmp_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("mismatches=%0d comparisons=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // each channel released at its own handshake; bready raised late on purpose
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awready) aw_ok = 1'b1;
      if (s_axi_wready) w_ok = 1'b1;
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    repeat (2) @(posedge aclk);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), (a > OFF_STATE) ? 32'(RESP_SLVERR) : 32'(RESP_OKAY));
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rresp = s_axi_rresp;
    check(s_axi_rdata, exp);
  endtask

  task automatic wait_irq();
    for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge aclk);
    check(32'(irq), 32'h1);
  endtask

  task automatic pulse(input int i);
    @(posedge aclk);
    trig_src[i] <= 1'b1;
    repeat (4) @(posedge aclk);
    trig_src[i] <= 1'b0;
  endtask

  task automatic t_reset_vals();
    logic [7:0] offs [7] = '{OFF_CTRL0, OFF_TRIG, OFF_RES_HI, OFF_RES_LO, OFF_INT_STAT, OFF_INT_MASK, OFF_STATE};
    foreach (offs[i]) rdchk(offs[i], 32'h0);
    rdchk(8'h40, 32'h0);
    check(32'(rresp), 32'(RESP_SLVERR));
    wr(8'h44, 8'h01);
    wr(OFF_RES_LO, 8'h55);
    rdchk(OFF_RES_LO, 32'h0);
  endtask

  task automatic t_sw_conv();
    vin = 10'h2a5;
    wr(OFF_INT_MASK, 8'h01);
    wr(OFF_CTRL0, 8'h03);
    rdchk(OFF_CTRL0, 32'h1);
    wr(OFF_CTRL0, 8'h03);
    check(32'(analog_drive.sample_en), 32'h1);
    rdchk(OFF_CTRL0, 32'h3);
    wait_irq();
    rdchk(OFF_CTRL0, 32'h1);
    rdchk(OFF_RES_HI, 32'h2);
    rdchk(OFF_RES_LO, 32'ha5);
    rdchk(OFF_INT_STAT, 32'h1);
    wr(OFF_INT_MASK, 8'h00);
    check(32'(irq), 32'h0);
    rdchk(OFF_INT_STAT, 32'h1);
    wr(OFF_INT_STAT, 8'h01);
    rdchk(OFF_INT_STAT, 32'h0);
    wr(OFF_INT_MASK, 8'h01);
  endtask

  task automatic t_abort();
    vin = 10'h2c7;
    wr(OFF_CTRL0, 8'h03);
    // abort lands near bit three; bits five to three are zero, so a fill of ones or no fill shows up
    repeat (30) @(posedge aclk);
    wr(OFF_CTRL0, 8'h01);
    rdchk(OFF_CTRL0, 32'h1);
    rdchk(OFF_RES_HI, 32'h2);
    rdchk(OFF_RES_LO, 32'hc0);
    rdchk(OFF_INT_STAT, 32'h0);
  endtask

  task automatic t_trig();
    for (int s = 1; s <= TRIG_N; s++) begin
      vin = 10'(s * 61);
      wr(OFF_TRIG, 8'(s));
      pulse(s % TRIG_N);
      repeat (70) @(posedge aclk);
      check(32'(irq), 32'h0);
      pulse(s - 1);
      wait_irq();
      rdchk(OFF_RES_LO, 32'(vin[7:0]));
      rdchk(OFF_RES_HI, 32'(vin[9:8]));
      wr(OFF_INT_STAT, 8'h01);
    end
    wr(OFF_CTRL0, 8'h00);
    pulse(TRIG_N - 1);
    repeat (70) @(posedge aclk);
    rdchk(OFF_INT_STAT, 32'h0);
    rdchk(OFF_CTRL0, 32'h0);
  endtask

  task automatic t_sleep_abort();
    wr(OFF_CTRL0, 8'h01);
    wr(OFF_CTRL0, 8'h03);
    repeat (20) @(posedge aclk);
    sleep_in <= 1'b1;
    repeat (3) @(posedge aclk);
    check(32'(converter_powered), 32'h0);
    rdchk(OFF_CTRL0, 32'h1);
    rdchk(OFF_INT_STAT, 32'h2);
    sleep_in <= 1'b0;
    wr(OFF_INT_STAT, 8'h03);
    check(32'(converter_powered), 32'h1);
  endtask

  task automatic t_sleep_rc();
    vin = 10'h0f0;
    wr(OFF_CTRL0, 8'h05);
    wr(OFF_CTRL0, 8'h07);
    check(32'(analog_drive.sample_en), 32'h0);
    sleep_in <= 1'b1;
    for (int i = 0; i < 300 && wake_req !== 1'b1; i++) @(posedge aclk);
    check(32'(wake_req), 32'h1);
    sleep_in <= 1'b0;
    rdchk(OFF_RES_LO, 32'hf0);
    wr(OFF_INT_STAT, 8'h01);
    wr(OFF_INT_MASK, 8'h00);
    wr(OFF_CTRL0, 8'h07);
    sleep_in <= 1'b1;
    for (int i = 0; i < 300 && converter_powered !== 1'b0; i++) @(posedge aclk);
    check(32'(converter_powered), 32'h0);
    rdchk(OFF_CTRL0, 32'h5);
    check(32'(wake_req), 32'h0);
    sleep_in <= 1'b0;
    wr(OFF_INT_STAT, 8'h01);
  endtask

  task automatic t_reset_mid();
    wr(OFF_CTRL0, 8'h03);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    check(32'(converter_powered), 32'h0);
    rdchk(OFF_CTRL0, 32'h0);
    rdchk(OFF_INT_MASK, 32'h0);
  endtask

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // whole run needs about 3000 cycles
  initial begin
    repeat (30000) @(posedge aclk);
    err_count++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset_vals();
    t_sw_conv();
    t_abort();
    t_trig();
    t_sleep_abort();
    t_sleep_rc();
    t_reset_mid();
    final_report();
  end
endmodule

bind adc_conversion_control adc_ctl_sva chk (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .analog_drive, .converter_powered, .wake_req,
  .irq, .sleep_in);
`default_nettype wire
